// ==== core/agcr_pkg.sv ====
package agcr_pkg;

   // bus geometry
   localparam int unsigned ADDR_W      = 8;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_INSTR  = 8'h04;
   localparam logic [7:0] OFS_WORK   = 8'h08;
   localparam logic [7:0] OFS_FILE   = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_PC     = 8'h14;
   localparam logic [7:0] OFS_PCHI   = 8'h18;
   localparam logic [7:0] OFS_CYCLES = 8'h1c;

   // control and status fields
   localparam int unsigned CTRL_TBL_INT = 0;
   localparam int unsigned CTRL_COND    = 1;
   localparam int unsigned CTRL_IRQ     = 2;
   localparam int unsigned ST_BUSY      = 8;
   localparam int unsigned ST_PROG      = 9;
   localparam int unsigned ST_DISCARD   = 10;

   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_PC   = 16'h0000;

   // opcode patterns, matched on the upper bits of the word; return and retfie on the whole word
   localparam logic [6:0]  OP_ADD_WF  = 7'h07;
   localparam logic [6:0]  OP_ADD_WFC = 7'h08;
   localparam logic [6:0]  OP_SETF   = 7'h15;
   localparam logic [6:0]  OP_NEGW   = 7'h16;
   localparam logic [6:0]  OP_INCFSZ = 7'h0f;
   localparam logic [6:0]  OP_INFSNZ = 7'h12;
   localparam logic [6:0]  OP_DCFSNZ = 7'h13;
   localparam logic [7:0]  OP_ADD_LIT   = 8'hb1;
   localparam logic [7:0]  OP_LONG_CALL = 8'hb7;
   localparam logic [7:0]  OP_RETLW  = 8'hb6;
   localparam logic [7:0]  OP_TSTFSZ = 8'h33;
   localparam logic [5:0]  OP_TBLRD  = 6'h2a;
   localparam logic [5:0]  OP_TBLWT  = 6'h2b;
   localparam logic [3:0]  OP_BTFS   = 4'h9;
   localparam logic [2:0]  OP_GOTO   = 3'h6;
   localparam logic [2:0]  OP_CALL   = 3'h7;
   localparam logic [15:0] OP_RETURN = 16'h0002;
   localparam logic [15:0] OP_RETFIE = 16'h0005;
   localparam logic [7:0]  PC_LOW_ADDR = 8'h02;

   // instruction cycle counts, four quarter phases each
   localparam logic [7:0] CYC_ONE   = 8'h01;
   localparam logic [7:0] CYC_TWO   = 8'h02;
   localparam logic [7:0] CYC_THREE = 8'h03;
   localparam logic [7:0] CYC_MAX   = 8'hff;
   localparam logic [1:0] QPH_FIRST = 2'h0;
   localparam logic [1:0] QPH_LAST  = 2'h3;

   typedef struct packed {
      logic ov;
      logic z;
      logic dc;
      logic c;
   } agcr_flags_t;

   typedef struct packed {
      logic [7:0]  sum;
      agcr_flags_t flags;
   } agcr_alu_res_t;

   typedef enum logic [1:0] {
      AGCR_IDLE = 2'b00,
      AGCR_RUN  = 2'b01,
      AGCR_PROG = 2'b11
   } agcr_state_t;

endpackage

// ==== core/agcr_alu.sv ====
`timescale 1ns/1ps
module agcr_alu (
   input  wire logic               [7:0] a,
   input  wire logic               [7:0] b,
   input  wire logic                     cin,
   output agcr_pkg::agcr_alu_res_t       res
);
   logic [4:0] lo;
   logic [4:0] hi;

   always_comb begin
      lo             = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi             = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      res.sum        = {hi[3:0], lo[3:0]};
      res.flags.c    = hi[4];
      res.flags.dc   = lo[4];
      res.flags.z    = ({hi[3:0], lo[3:0]} == 8'h00);
      // signed overflow: like signs in, other sign out
      res.flags.ov   = (a[7] == b[7]) && (hi[3] != a[7]);
   end
endmodule // agcr_alu

// ==== core/agcr_core.sv ====
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// - add w to file: sum, four flags, dest
// - store bit one: file only; zero: both
// - long call: pc high from latch, low literal
// - internal table write runs until interrupt event
// - external table write takes two cycles
// - skip: two cycles if true, else one
// - branch, table read two; to pc low three
// - taken skip discards prefetched word, runs nop
module agcr_core (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   logic                    aw_have;
   logic                    w_have;
   logic [7:0]              awaddr_q;
   logic [31:0]             wdata_q;
   logic [3:0]              wstrb_q;
   logic                    wr_fire;
   logic                    wr_ok;
   logic                    rd_ok;
   logic [31:0]             rd_val;
   logic [2:0]              ctrl;
   logic [7:0]              working_register;
   logic [7:0]              file_reg;
   logic [15:0]             pc;
   logic [7:0]              pc_high_latch;
   logic [15:0]             last_op;
   agcr_pkg::agcr_flags_t   flags;
   agcr_pkg::agcr_state_t   state;
   logic [1:0]              qph;
   logic [7:0]              cyc_cnt;
   logic [7:0]              cyc_target;
   logic                    discard_pending;
   logic                    issue;
   logic                    exec;
   logic                    irq_event;
   logic [15:0]             op;
   logic                    is_add_wf;
   logic                    is_add_wfc;
   logic                    is_add_lit;
   logic                    is_setf;
   logic                    is_negw;
   logic                    is_skip;
   logic                    is_long_call;
   logic                    is_branch;
   logic                    is_tblrd;
   logic                    is_tblwt;
   logic                    dbit;
   logic [7:0]              next_cycles;
   logic [7:0]              alu_a;
   logic [7:0]              alu_b;
   logic                    alu_cin;
   agcr_pkg::agcr_alu_res_t alu_res;

   assign wr_fire   = aw_have && w_have && !bvalid;
   assign issue     = wr_fire && (awaddr_q == agcr_pkg::OFS_INSTR) && (wstrb_q[1:0] == 2'h3)
                      && (state == agcr_pkg::AGCR_IDLE);
   assign exec      = issue && !discard_pending;
   assign irq_event = wr_fire && (awaddr_q == agcr_pkg::OFS_CTRL) && wstrb_q[0]
                      && wdata_q[agcr_pkg::CTRL_IRQ];
   assign op        = wdata_q[15:0];
   assign dbit      = op[8];

   always_comb begin
      case (awaddr_q)
         agcr_pkg::OFS_CTRL, agcr_pkg::OFS_INSTR, agcr_pkg::OFS_WORK, agcr_pkg::OFS_FILE,
         agcr_pkg::OFS_STATUS, agcr_pkg::OFS_PC, agcr_pkg::OFS_PCHI: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // decode
   always_comb begin
      is_add_wf  = op[15:9] == agcr_pkg::OP_ADD_WF;
      is_add_wfc = op[15:9] == agcr_pkg::OP_ADD_WFC;
      is_add_lit = op[15:8] == agcr_pkg::OP_ADD_LIT;
      is_setf   = op[15:9] == agcr_pkg::OP_SETF;
      is_negw   = op[15:9] == agcr_pkg::OP_NEGW;
      is_skip   = (op[15:12] == agcr_pkg::OP_BTFS) || (op[15:8] == agcr_pkg::OP_TSTFSZ)
                  || (op[15:9] == agcr_pkg::OP_INCFSZ) || (op[15:9] == agcr_pkg::OP_INFSNZ)
                  || (op[15:9] == agcr_pkg::OP_DCFSNZ);
      is_long_call = op[15:8] == agcr_pkg::OP_LONG_CALL;
      is_branch = (op[15:13] == agcr_pkg::OP_GOTO) || (op[15:13] == agcr_pkg::OP_CALL)
                  || is_long_call || (op[15:8] == agcr_pkg::OP_RETLW)
                  || (op == agcr_pkg::OP_RETURN) || (op == agcr_pkg::OP_RETFIE);
      is_tblrd  = op[15:10] == agcr_pkg::OP_TBLRD;
      is_tblwt  = op[15:10] == agcr_pkg::OP_TBLWT;
      if (is_tblrd && (op[7:0] == agcr_pkg::PC_LOW_ADDR)) begin
         next_cycles = agcr_pkg::CYC_THREE;
      end else if (is_branch || is_tblrd || is_tblwt || (is_skip && ctrl[agcr_pkg::CTRL_COND])) begin
         next_cycles = agcr_pkg::CYC_TWO;
      end else begin
         next_cycles = agcr_pkg::CYC_ONE;
      end
      // negate runs as ~w + 0 + 1
      alu_a   = is_negw ? ~working_register : working_register;
      alu_b   = is_add_lit ? op[7:0] : (is_negw ? 8'h00 : file_reg);
      alu_cin = is_add_wfc ? flags.c : is_negw;
   end

   agcr_alu u_alu (
      .a   (alu_a),
      .b   (alu_b),
      .cin (alu_cin),
      .res (alu_res)
   );

   // write address and data, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have  <= 1'b0;
         awready  <= 1'b0;
         awaddr_q <= agcr_pkg::RST_BYTE;
      end else if (awvalid && awready) begin
         aw_have  <= 1'b1;
         awready  <= 1'b0;
         awaddr_q <= awaddr;
      end else if (wr_fire) begin
         aw_have  <= 1'b0;
      end else if (!aw_have && !bvalid) begin
         awready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have  <= 1'b0;
         wready  <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         w_have  <= 1'b1;
         wready  <= 1'b0;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wr_fire) begin
         w_have  <= 1'b0;
      end else if (!w_have && !bvalid) begin
         wready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= agcr_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? agcr_pkg::RESP_OKAY : agcr_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // read channel
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (araddr)
         agcr_pkg::OFS_CTRL:   rd_val[2:0]  = ctrl;
         agcr_pkg::OFS_INSTR:  rd_val[15:0] = last_op;
         agcr_pkg::OFS_WORK:   rd_val[7:0]  = working_register;
         agcr_pkg::OFS_FILE:   rd_val[7:0]  = file_reg;
         agcr_pkg::OFS_STATUS: begin
            rd_val[3:0]                   = flags;
            rd_val[agcr_pkg::ST_BUSY]     = state != agcr_pkg::AGCR_IDLE;
            rd_val[agcr_pkg::ST_PROG]     = state == agcr_pkg::AGCR_PROG;
            rd_val[agcr_pkg::ST_DISCARD]  = discard_pending;
         end
         agcr_pkg::OFS_PC:     rd_val[15:0] = pc;
         agcr_pkg::OFS_PCHI:   rd_val[7:0]  = pc_high_latch;
         agcr_pkg::OFS_CYCLES: rd_val[7:0]  = cyc_cnt;
         default:              rd_ok        = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= agcr_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_val;
         rresp   <= rd_ok ? agcr_pkg::RESP_OKAY : agcr_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // control; irq bit is a pulse and never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= 3'h0;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_CTRL) && wstrb_q[0]) begin
         ctrl <= {1'b0, wdata_q[1:0]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_op <= 16'h0000;
      end else if (issue) begin
         last_op <= op;
      end
   end

   // working register: add literal always writes it; other instructions only when the d bit is zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         working_register <= agcr_pkg::RST_BYTE;
      end else if (exec && (is_add_lit || ((is_add_wf || is_add_wfc || is_negw) && !dbit))) begin
         working_register <= alu_res.sum;
      end else if (exec && is_setf && !dbit) begin
         working_register <= 8'hff;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_WORK) && wstrb_q[0]) begin
         working_register <= wdata_q[7:0];
      end
   end

   // addressed file register image
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         file_reg <= agcr_pkg::RST_BYTE;
      end else if (exec && (((is_add_wf || is_add_wfc) && dbit) || is_negw)) begin
         file_reg <= alu_res.sum;
      end else if (exec && is_setf) begin
         file_reg <= 8'hff;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_FILE) && wstrb_q[0]) begin
         file_reg <= wdata_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
      end else if (exec && (is_add_wf || is_add_wfc || is_add_lit || is_negw)) begin
         flags <= alu_res.flags;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_STATUS) && wstrb_q[0]) begin
         flags <= wdata_q[3:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc <= agcr_pkg::RST_PC;
      end else if (exec && is_long_call) begin
         pc <= {pc_high_latch, op[7:0]};
      end else if (issue) begin
         pc <= pc + 16'h0001;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_PC)) begin
         pc <= (pc & ~{{8{wstrb_q[1]}}, {8{wstrb_q[0]}}})
               | (wdata_q[15:0] & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_high_latch <= agcr_pkg::RST_BYTE;
      end else if (wr_fire && (awaddr_q == agcr_pkg::OFS_PCHI) && wstrb_q[0]) begin
         pc_high_latch <= wdata_q[7:0];
      end
   end

   // prefetched word after a taken skip is dropped; its slot is the skip's nop cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         discard_pending <= 1'b0;
      end else if (exec && is_skip && ctrl[agcr_pkg::CTRL_COND]) begin
         discard_pending <= 1'b1;
      end else if (issue) begin
         discard_pending <= 1'b0;
      end
   end

   // cycle sequencer, four clocks per instruction cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state      <= agcr_pkg::AGCR_IDLE;
         qph        <= agcr_pkg::QPH_FIRST;
         cyc_cnt    <= agcr_pkg::RST_BYTE;
         cyc_target <= agcr_pkg::RST_BYTE;
      end else begin
         unique case (state)
            agcr_pkg::AGCR_IDLE: begin
               if (exec) begin
                  qph        <= agcr_pkg::QPH_FIRST;
                  cyc_cnt    <= agcr_pkg::CYC_ONE;
                  cyc_target <= next_cycles;
                  if (is_tblwt && ctrl[agcr_pkg::CTRL_TBL_INT]) begin
                     state <= agcr_pkg::AGCR_PROG;
                  end else begin
                     state <= agcr_pkg::AGCR_RUN;
                  end
               end
            end
            agcr_pkg::AGCR_RUN: begin
               qph <= qph + 2'h1;
               if (qph == agcr_pkg::QPH_LAST) begin
                  if (cyc_cnt == cyc_target) begin
                     state <= agcr_pkg::AGCR_IDLE;
                  end else begin
                     cyc_cnt <= cyc_cnt + 8'h01;
                  end
               end
            end
            agcr_pkg::AGCR_PROG: begin
               // programming has no length of its own; only an interrupt ends it
               if (irq_event) begin
                  state <= agcr_pkg::AGCR_IDLE;
               end else begin
                  qph <= qph + 2'h1;
                  if ((qph == agcr_pkg::QPH_LAST) && (cyc_cnt != agcr_pkg::CYC_MAX)) begin
                     cyc_cnt <= cyc_cnt + 8'h01;
                  end
               end
            end
            default: state <= agcr_pkg::AGCR_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_busy_two;
      (state != agcr_pkg::AGCR_IDLE) [*8] ##1 (state == agcr_pkg::AGCR_IDLE);
   endsequence

   sequence s_busy_one;
      (state != agcr_pkg::AGCR_IDLE) [*4] ##1 (state == agcr_pkg::AGCR_IDLE);
   endsequence

   AST_ADD_WF_RESULT: assert property (
      exec && is_add_wf |=> (dbit ? file_reg : working_register)
         == $past(working_register) + $past(file_reg) && !flags.z == |$past(alu_res.sum))
      else $error("add w to file result or zero flag wrong");

   AST_STORE_SELECT: assert property (
      exec && is_setf && dbit |=> file_reg == 8'hff && $stable(working_register))
      else $error("store bit one touched working register");

   AST_LONG_CALL: assert property (
      exec && is_long_call |=> pc == {$past(pc_high_latch), $past(op[7:0])})
      else $error("long call target wrong");

   AST_TBLWT_INT: assert property (
      exec && is_tblwt && ctrl[agcr_pkg::CTRL_TBL_INT] && !irq_event
      |=> (state == agcr_pkg::AGCR_PROG) [*2])
      else $error("internal table write did not hold");

   AST_TBLWT_STOP: assert property (
      state == agcr_pkg::AGCR_PROG && irq_event |=> state == agcr_pkg::AGCR_IDLE)
      else $error("interrupt did not end programming");

   AST_TBLWT_EXT: assert property (
      exec && is_tblwt && !ctrl[agcr_pkg::CTRL_TBL_INT] |=> s_busy_two)
      else $error("external table write not two cycles");

   AST_SKIP_TRUE: assert property (
      exec && is_skip && ctrl[agcr_pkg::CTRL_COND] |=> s_busy_two)
      else $error("taken skip not two cycles");

   AST_SKIP_FALSE: assert property (
      exec && is_skip && !ctrl[agcr_pkg::CTRL_COND] |=> s_busy_one)
      else $error("untaken skip not one cycle");

   AST_TBLRD_LOW: assert property (
      exec && is_tblrd && op[7:0] == agcr_pkg::PC_LOW_ADDR
      |=> (state != agcr_pkg::AGCR_IDLE) [*8] ##1 (state != agcr_pkg::AGCR_IDLE) [*4]
          ##1 (state == agcr_pkg::AGCR_IDLE && cyc_cnt == agcr_pkg::CYC_THREE))
      else $error("table read to pc low byte not three cycles");

   AST_DISCARD: assert property (
      issue && discard_pending |=> $stable(working_register) && $stable(file_reg)
         && !discard_pending && state == agcr_pkg::AGCR_IDLE)
      else $error("prefetched word not discarded");

   AST_ADD_LIT: assert property (
      exec && is_add_lit |=> working_register == $past(working_register) + $past(op[7:0])
         ##0 s_busy_one)
      else $error("add literal wrong");

   AST_ADD_WFC: assert property (
      exec && is_add_wfc && !dbit |=> working_register
         == $past(working_register) + $past(file_reg) + {7'h00, $past(flags.c)})
      else $error("add with carry wrong");

endmodule // agcr_core

// ==== tb/add_group_and_cycle_rules_bench.sv ====
`timescale 1ns/1ps
module add_group_and_cycle_rules_bench;
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic [31:0] seed;
   logic [31:0] v;
   logic [1:0]  resp;
   logic [15:0] cop [7];
   int          ccy [7];
   int          err_count;
   int          n_tests;
   int          m_w;
   int          m_f;
   int          m_fl;
   int          m_pc;

   agcr_core dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);

   always #5 aclk = ~aclk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // packs flags {ov,z,dc,c} above the 8-bit sum
   function automatic int m_add(input int a, input int b, input int ci);
      int r;
      int s;
      r = a + b + ci;
      s = r & 255;
      return ((((a ^ s) & (b ^ s) & 128) != 0) << 11) | ((s == 0) << 10)
         | ((((a & 15) + (b & 15) + ci) > 15) << 9) | ((r > 255) << 8) | s;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_resp(input logic [1:0] e);
      chk("response", {30'h0, e}, {30'h0, resp});
   endtask

   // next request waits one edge so no signal is assigned twice in a step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ad;
      bit wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            resp = bresp;
            break;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bit ad;
      ad = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (!ad && arready === 1'b1) begin
            ad = 1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            d = rdata;
            resp = rresp;
            break;
         end
      end
      rready <= 1'b0;
   endtask

   task automatic issue(input logic [15:0] op);
      wr(agcr_pkg::OFS_INSTR, {16'h0000, op});
      do rd(agcr_pkg::OFS_STATUS, v); while (v[agcr_pkg::ST_BUSY] !== 1'b0);
   endtask

   task automatic set_wf(input int w, input int f, input int fl);
      m_w = w;
      m_f = f;
      m_fl = fl;
      wr(agcr_pkg::OFS_WORK, w);
      wr(agcr_pkg::OFS_FILE, f);
      wr(agcr_pkg::OFS_STATUS, fl);
   endtask

   task automatic check_state(input string nm);
      rd(agcr_pkg::OFS_WORK, v);
      chk("working_register", m_w, v);
      rd(agcr_pkg::OFS_FILE, v);
      chk("file", m_f, v);
      rd(agcr_pkg::OFS_STATUS, v);
      chk("flags", m_fl, v & 32'hf);
      rd(agcr_pkg::OFS_PC, v);
      chk("pc", m_pc, v);
      $display("test %s done", nm);
   endtask

   task automatic cycles(input int n);
      rd(agcr_pkg::OFS_CYCLES, v);
      chk("cycles", n, v);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      err_count++;
      stop_test();
   end

   initial begin
      logic [7:0] wb;
      logic [7:0] lb;
      logic       db;
      logic [15:0] op;
      int         r;
      aclk = 0;
      aresetn = 0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      seed = 32'h41;
      err_count = 0;
      n_tests = 0;
      {m_w, m_f, m_fl, m_pc} = '0;
      cop = '{16'hc123, 16'he456, agcr_pkg::OP_RETURN, {agcr_pkg::OP_TBLRD, 2'b00,
         agcr_pkg::PC_LOW_ADDR}, {agcr_pkg::OP_TBLRD, 10'h010}, {agcr_pkg::OP_TBLWT, 10'h010},
         {agcr_pkg::OP_BTFS, 12'h010}};
      ccy = '{2, 2, 2, 3, 2, 2, 1};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      check_state("reset");
      for (int i = 0; i < 6; i++) begin
         wb = rnd();
         lb = rnd();
         db = i[0];
         set_wf(wb, lb, rnd() & 1);
         op = (i < 2) ? {agcr_pkg::OP_ADD_WF, db, 8'h10} : (i < 4) ?
            {agcr_pkg::OP_ADD_WFC, db, 8'h10} : {agcr_pkg::OP_ADD_LIT, lb};
         r = m_add(wb, lb, (i >= 2 && i < 4) ? (m_fl & 1) : 0);
         if (i >= 4 || !db) m_w = r & 255;
         else m_f = r & 255;
         m_fl = r >> 8;
         m_pc++;
         issue(op);
         check_state("add");
         cycles(1);
      end
      for (int i = 0; i < 2; i++) begin
         set_wf(rnd() & 255, rnd() & 255, rnd() & 15);
         issue({agcr_pkg::OP_SETF, i[0], 8'h10});
         m_f = 255;
         if (i == 0) m_w = 255;
         m_pc++;
         check_state("store select");
      end
      wb = rnd();
      lb = rnd();
      wr(agcr_pkg::OFS_PCHI, wb);
      issue({agcr_pkg::OP_LONG_CALL, lb});
      m_pc = {wb, lb};
      check_state("long call");
      cycles(2);
      for (int i = 0; i < 7; i++) begin
         issue(cop[i]);
         m_pc++;
         cycles(ccy[i]);
         rd(agcr_pkg::OFS_PC, v);
         chk("pc", m_pc, v);
      end
      $display("test cycle counts done");
      wr(agcr_pkg::OFS_CTRL, 32'h2);
      set_wf(rnd() & 255, rnd() & 255, 0);
      issue({agcr_pkg::OP_BTFS, 12'h010});
      cycles(2);
      rd(agcr_pkg::OFS_STATUS, v);
      chk("discard", 1, v[agcr_pkg::ST_DISCARD]);
      issue({agcr_pkg::OP_ADD_LIT, 8'h5a});
      m_pc += 2;
      check_state("skip taken");
      wr(agcr_pkg::OFS_CTRL, 32'h1);
      wr(agcr_pkg::OFS_INSTR, {agcr_pkg::OP_TBLWT, 10'h010});
      repeat (4) rd(agcr_pkg::OFS_STATUS, v);
      chk("programming", 3, v[9:8]);
      wr(agcr_pkg::OFS_CTRL, 32'h5);
      chk_resp(agcr_pkg::RESP_OKAY);
      rd(agcr_pkg::OFS_STATUS, v);
      chk("programming end", 0, v[9:8]);
      wr(agcr_pkg::OFS_CTRL, 32'h0);
      $display("test internal table write done");
      wr(8'h40, rnd());
      chk_resp(agcr_pkg::RESP_SLVERR);
      rd(8'h40, v);
      chk_resp(agcr_pkg::RESP_SLVERR);
      chk("unmapped data", 0, v);
      $display("test unmapped done");
      stop_test();
   end
endmodule // add_group_and_cycle_rules_bench
